// ==== hdl/hmp_pkg.sv ====
// shared constants and types of the haptic mode and process control block
package hmp_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_MODE = 8'h01;
    localparam logic [7:0] ADDR_FIRE = 8'h0C;
    localparam logic [7:0] ADDR_NOMINAL = 8'h16;
    localparam logic [7:0] ADDR_OVERDRIVE = 8'h17;
    localparam int RST_BIT = 7;
    localparam int STBY_BIT = 6;
    localparam int MODE_MSB = 2;
    localparam int MODE_LSB = 0;
    localparam int FIRE_BIT = 0;
    localparam logic STBY_RST_VAL = 1'b1;
    localparam logic [7:0] NOMINAL_RST_VAL = 8'h3F;
    localparam logic [7:0] OVERDRIVE_RST_VAL = 8'h89;
    localparam logic [7:0] RDATA_ZERO = 8'h00;

    typedef enum logic [2:0] {
        MODE_INT_TRIG = 3'h0,
        MODE_EDGE_TRIG = 3'h1,
        MODE_LEVEL_TRIG = 3'h2,
        MODE_ANALOG_PWM = 3'h3,
        MODE_AUDIO_VIBE = 3'h4,
        MODE_REALTIME = 3'h5,
        MODE_DIAG = 3'h6,
        MODE_CAL = 3'h7
    } hmp_mode_t;

    // ****************************************
    // back-emf timing, one code step each
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALF_UNIT_NS = 100000;
    localparam int DISS_UNIT_NS = 25000;
    localparam int BLANK_UNIT_NS = 5000;
    localparam int HALF_UNIT_CYC = (HALF_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DISS_UNIT_CYC = (DISS_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_UNIT_CYC = (BLANK_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SENSE_CNT_W = 20;

    typedef enum logic [3:0] {
        ST_DRIVE = 4'b0001,
        ST_DISS = 4'b0010,
        ST_BLANK = 4'b0100,
        ST_CONV = 4'b1000
    } hmp_sense_st_t;
endpackage

// ==== hdl/hmp_sync.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module hmp_sync (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic async_in,
    output logic sync_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic out_ff;
    logic nxt_out;

    // first stage feeds only the second one
    always_comb
    begin
        nxt_out = (s2_ff == s3_ff) ? s2_ff : out_ff;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            out_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign sync_out = out_ff;
endmodule
`default_nettype wire

// ==== hdl/hmp_sense_timer.sv ====
// drive, dissipation, blanking and conversion sequencer of the output stage
`timescale 1ns/1ns
`default_nettype none
module hmp_sense_timer
    import hmp_pkg::*;
#(
    parameter int HALF_CYC = hmp_pkg::HALF_UNIT_CYC,
    parameter int CNT_W = hmp_pkg::SENSE_CNT_W
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic run,
    input wire logic lra_open,
    input wire logic is_lra,
    input wire logic [4:0] half_period,
    input wire logic [1:0] diss_time,
    input wire logic [1:0] blank_time,
    output logic out_p,
    output logic out_n,
    output logic out_hiz,
    output logic adc_start
);
    hmp_sense_st_t st_ff, nxt_st;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt, drive_load, diss_load, blank_load;
    logic pol_ff, nxt_pol, p_ff, n_ff, hiz_ff, adc_ff;
    logic nxt_p, nxt_n, nxt_hiz, nxt_adc;

    // code 0 still gives one unit, so no phase is ever empty
    assign drive_load = CNT_W'((int'(half_period) + 1) * HALF_CYC - 1);
    assign diss_load = CNT_W'((int'(diss_time) + 1) * DISS_UNIT_CYC - 1);
    assign blank_load = CNT_W'((int'(blank_time) + 1) * BLANK_UNIT_CYC - 1);

    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff - CNT_W'(1);
        nxt_pol = pol_ff;
        nxt_adc = 1'b0;
        if (!run)
        begin
            nxt_st = ST_DRIVE;
            nxt_cnt = drive_load;
            nxt_pol = 1'b1;
        end
        else
        begin
            unique case (st_ff)
                ST_DRIVE:
                    if (cnt_ff == '0)
                    begin
                        if (lra_open)
                        begin
                            nxt_pol = ~pol_ff;
                            nxt_cnt = drive_load;
                        end
                        else
                        begin
                            nxt_st = ST_DISS;
                            nxt_cnt = diss_load;
                        end
                    end
                ST_DISS:
                    if (cnt_ff == '0)
                    begin
                        nxt_st = ST_BLANK;
                        nxt_cnt = blank_load;
                    end
                ST_BLANK:
                    if (cnt_ff == '0)
                    begin
                        nxt_st = ST_CONV;
                        nxt_adc = 1'b1;
                    end
                ST_CONV:
                begin
                    nxt_st = ST_DRIVE;
                    nxt_cnt = drive_load;
                    nxt_pol = is_lra ? ~pol_ff : pol_ff;
                end
            endcase
        end
        // dissipation drives both legs low so coil current decays
        nxt_p = run && (nxt_st == ST_DRIVE) && nxt_pol;
        nxt_n = run && (nxt_st == ST_DRIVE) && !nxt_pol;
        nxt_hiz = run && ((nxt_st == ST_BLANK) || (nxt_st == ST_CONV));
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff <= ST_DRIVE;
            cnt_ff <= '0;
            pol_ff <= 1'b1;
            p_ff <= 1'b0;
            n_ff <= 1'b0;
            hiz_ff <= 1'b0;
            adc_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            pol_ff <= nxt_pol;
            p_ff <= nxt_p;
            n_ff <= nxt_n;
            hiz_ff <= nxt_hiz;
            adc_ff <= nxt_adc;
        end
    end

    assign out_p = p_ff;
    assign out_n = n_ff;
    assign out_hiz = hiz_ff;
    assign adc_start = adc_ff;
endmodule
`default_nettype wire

// ==== hdl/hmp_mode_ctrl.sv ====
// mode, reset, fire and short handling of the haptic driver
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - reset bit acts as power cycle, stops playback, restores defaults, then self-clears.
// - processes start only on the internal fire signal, not the fire bit.
// - short present before playback blocks it until the mode field changes.
// - mode field decodes to the eight trigger, input, diagnostic and calibration modes.
// - fire plays the sequencer list, or starts calibration or diagnostics.
// - internal mode: writing one sets fire bit, cleared when sequence finishes.
// - host clearing the fire bit cancels the remaining sequence at once.
// - external trigger modes: readable fire bit shows the trigger state.
// - realtime, pwm and audio modes assert fire signal, fire bit untouched.
// - open-loop linear actuator toggles outputs at the programmed half period.
// - shorted regulator pin shuts down; restart in defaults after removal.
// - output short during a process sets overcurrent flag until removed.
// - output shorts are only checked while a process runs or tries to launch; regulator shorts always.
// - half period is the initial estimate for the resonance tracker.
// - rotating mass: half period sets the back-emf sampling interval.
// - current decays for dissipation time before outputs go high impedance.
// - settle blank time elapses before back-emf conversion starts.
// - closed loop uses nominal drive level as steady-state amplitude.
// - open loop ignores nominal level and uses overdrive limit.
// - overdrive limit bounds peak and wins over a higher nominal level.
// - linear actuator peak output scales with the overdrive limit code.
// - edge mode: rising edge sets fire bit, another rising edge clears it.
// - level mode: fire bit follows the trigger pin.
// - standby bit stops any waveform at once and keeps registers, except the fire bit, which it holds cleared.
module hmp_mode_ctrl
    import hmp_pkg::*;
#(
    parameter int HALF_UNIT_CYC = hmp_pkg::HALF_UNIT_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic trigger_input_pin,
    input wire logic regulator_pin_short,
    input wire logic output_short_sense,
    input wire logic pwm_not_analog_select,
    input wire logic actuator_is_lra,
    input wire logic open_loop_select,
    input wire logic [4:0] drive_half_period,
    input wire logic [1:0] dissipation_time,
    input wire logic [1:0] settle_blank_time,
    input wire logic sequence_done,
    output logic fire_signal,
    output logic process_start,
    output hmp_pkg::hmp_mode_t active_mode,
    output logic pwm_input_active,
    output logic analog_input_active,
    output logic standby_active,
    output logic device_shutdown,
    output logic overcurrent_flag,
    output logic current_cut,
    output logic [7:0] drive_amplitude,
    output logic [7:0] peak_limit,
    output logic drive_out_p,
    output logic drive_out_n,
    output logic output_hiz,
    output logic adc_start
);
    import hmp_pkg::*;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic trig_s;
    logic reg_short_s;
    logic out_short_s;

    hmp_sync u_sync_trig (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in(trigger_input_pin),
        .sync_out(trig_s)
    );

    hmp_sync u_sync_reg (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in(regulator_pin_short),
        .sync_out(reg_short_s)
    );

    hmp_sync u_sync_out (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in(output_short_sense),
        .sync_out(out_short_s)
    );

    // ****************************************
    // control registers
    // ****************************************
    hmp_mode_t mode_ff, nxt_mode;
    logic standby_ff, nxt_standby;
    logic full_reset_ff, nxt_full_reset;
    logic fire_bit_ff, nxt_fire_bit;
    logic trig_prev_ff, nxt_trig_prev;
    logic [7:0] nominal_ff, nxt_nominal;
    logic [7:0] overdrive_ff, nxt_overdrive;
    logic soft_rst;
    logic wr_mode;
    logic wr_fire;
    logic mode_changed;
    logic trig_rise;
    logic cont_mode;

    // a shorted regulator holds the whole register set at its defaults
    assign soft_rst = full_reset_ff || reg_short_s;
    assign wr_mode = reg_wr_en && (reg_addr == ADDR_MODE);
    assign wr_fire = reg_wr_en && (reg_addr == ADDR_FIRE);
    assign mode_changed = wr_mode
        && (hmp_mode_t'(reg_wdata[MODE_MSB:MODE_LSB]) != mode_ff);
    assign trig_rise = trig_s && !trig_prev_ff;
    assign cont_mode = (mode_ff == MODE_ANALOG_PWM)
        || (mode_ff == MODE_AUDIO_VIBE)
        || (mode_ff == MODE_REALTIME);

    always_comb
    begin
        nxt_mode = mode_ff;
        nxt_standby = standby_ff;
        nxt_full_reset = 1'b0;
        nxt_fire_bit = fire_bit_ff;
        nxt_trig_prev = trig_s;
        nxt_nominal = nominal_ff;
        nxt_overdrive = overdrive_ff;
        if (soft_rst)
        begin
            nxt_mode = MODE_INT_TRIG;
            nxt_standby = STBY_RST_VAL;
            nxt_fire_bit = 1'b0;
            nxt_nominal = NOMINAL_RST_VAL;
            nxt_overdrive = OVERDRIVE_RST_VAL;
        end
        else
        begin
            if (wr_mode)
            begin
                nxt_mode = hmp_mode_t'(reg_wdata[MODE_MSB:MODE_LSB]);
                nxt_standby = reg_wdata[STBY_BIT];
                nxt_full_reset = reg_wdata[RST_BIT];
            end
            if (reg_wr_en && (reg_addr == ADDR_NOMINAL))
            begin
                nxt_nominal = reg_wdata;
            end
            if (reg_wr_en && (reg_addr == ADDR_OVERDRIVE))
            begin
                nxt_overdrive = reg_wdata;
            end
            if (standby_ff)
            begin
                nxt_fire_bit = 1'b0;
            end
            else if (mode_ff == MODE_LEVEL_TRIG)
            begin
                nxt_fire_bit = trig_s;
            end
            else
            begin
                // completion clears first so a write or edge in the same cycle wins
                if (sequence_done)
                begin
                    nxt_fire_bit = 1'b0;
                end
                if (wr_fire)
                begin
                    nxt_fire_bit = reg_wdata[FIRE_BIT];
                end
                if ((mode_ff == MODE_EDGE_TRIG) && trig_rise)
                begin
                    nxt_fire_bit = !fire_bit_ff;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_ff <= MODE_INT_TRIG;
            standby_ff <= STBY_RST_VAL;
            full_reset_ff <= 1'b0;
            fire_bit_ff <= 1'b0;
            trig_prev_ff <= 1'b0;
            nominal_ff <= NOMINAL_RST_VAL;
            overdrive_ff <= OVERDRIVE_RST_VAL;
        end
        else
        begin
            mode_ff <= nxt_mode;
            standby_ff <= nxt_standby;
            full_reset_ff <= nxt_full_reset;
            fire_bit_ff <= nxt_fire_bit;
            trig_prev_ff <= nxt_trig_prev;
            nominal_ff <= nxt_nominal;
            overdrive_ff <= nxt_overdrive;
        end
    end

    // ****************************************
    // fire signal, shorts and drive levels
    // ****************************************
    logic fire_sig_ff, nxt_fire_sig;
    logic start_ff, nxt_start;
    logic block_ff, nxt_block;
    logic oc_ff, nxt_oc;
    logic cut_ff;
    logic shut_ff;
    hmp_mode_t amode_ff;
    logic pwm_ff, nxt_pwm;
    logic analog_ff, nxt_analog;
    logic [7:0] amp_ff, nxt_amp;
    logic [7:0] peak_ff;
    logic fire_raw;

    assign fire_raw = (fire_bit_ff || cont_mode) && !standby_ff && !soft_rst;

    always_comb
    begin
        nxt_block = block_ff;
        if (mode_changed || soft_rst)
        begin
            nxt_block = 1'b0;
        end
        // a short found at launch wins over a mode write in the same cycle
        if (fire_raw && !fire_sig_ff && out_short_s)
        begin
            nxt_block = 1'b1;
        end
        nxt_fire_sig = fire_raw && !nxt_block;
        nxt_start = nxt_fire_sig && !fire_sig_ff;
        // checked only while a process runs or tries to launch
        nxt_oc = out_short_s && (oc_ff || fire_sig_ff || (fire_raw && nxt_block));
        nxt_pwm = (mode_ff == MODE_ANALOG_PWM) && pwm_not_analog_select;
        nxt_analog = (mode_ff == MODE_ANALOG_PWM) && !pwm_not_analog_select;
        if (open_loop_select)
        begin
            nxt_amp = overdrive_ff;
        end
        else if (nominal_ff > overdrive_ff)
        begin
            nxt_amp = overdrive_ff;
        end
        else
        begin
            nxt_amp = nominal_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fire_sig_ff <= 1'b0;
            start_ff <= 1'b0;
            block_ff <= 1'b0;
            oc_ff <= 1'b0;
            cut_ff <= 1'b0;
            shut_ff <= 1'b0;
            amode_ff <= MODE_INT_TRIG;
            pwm_ff <= 1'b0;
            analog_ff <= 1'b0;
            amp_ff <= NOMINAL_RST_VAL;
            peak_ff <= OVERDRIVE_RST_VAL;
        end
        else
        begin
            fire_sig_ff <= nxt_fire_sig;
            start_ff <= nxt_start;
            block_ff <= nxt_block;
            oc_ff <= nxt_oc;
            cut_ff <= nxt_oc;
            shut_ff <= reg_short_s;
            amode_ff <= mode_ff;
            pwm_ff <= nxt_pwm;
            analog_ff <= nxt_analog;
            amp_ff <= nxt_amp;
            peak_ff <= overdrive_ff;
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    logic [7:0] rdata_ff, nxt_rdata;

    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (reg_rd_en)
        begin
            nxt_rdata = RDATA_ZERO;
            unique case (reg_addr)
                ADDR_MODE:
                begin
                    nxt_rdata[RST_BIT] = full_reset_ff;
                    nxt_rdata[STBY_BIT] = standby_ff;
                    nxt_rdata[MODE_MSB:MODE_LSB] = mode_ff;
                end
                ADDR_FIRE: nxt_rdata[FIRE_BIT] = fire_bit_ff;
                ADDR_NOMINAL: nxt_rdata = nominal_ff;
                ADDR_OVERDRIVE: nxt_rdata = overdrive_ff;
                default: nxt_rdata = RDATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_ff <= RDATA_ZERO;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************
    // output stage sequencer
    // ****************************************
    hmp_sense_timer #(
        .HALF_CYC(HALF_UNIT_CYC),
        .CNT_W(SENSE_CNT_W)
    ) u_sense (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(fire_sig_ff && !oc_ff),
        .lra_open(actuator_is_lra && open_loop_select),
        .is_lra(actuator_is_lra),
        .half_period(drive_half_period),
        .diss_time(dissipation_time),
        .blank_time(settle_blank_time),
        .out_p(drive_out_p),
        .out_n(drive_out_n),
        .out_hiz(output_hiz),
        .adc_start(adc_start)
    );

    assign reg_rdata = rdata_ff;
    assign fire_signal = fire_sig_ff;
    assign process_start = start_ff;
    assign active_mode = amode_ff;
    assign pwm_input_active = pwm_ff;
    assign analog_input_active = analog_ff;
    assign standby_active = standby_ff;
    assign device_shutdown = shut_ff;
    assign overcurrent_flag = oc_ff;
    assign current_cut = cut_ff;
    assign drive_amplitude = amp_ff;
    assign peak_limit = peak_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    reset_restore_a: assert property (full_reset_ff |=> !full_reset_ff && standby_ff
        && (mode_ff == MODE_INT_TRIG) && !fire_sig_ff && (overdrive_ff == OVERDRIVE_RST_VAL))
        else $error("full reset did not restore defaults");
    start_fire_a: assert property (start_ff |-> fire_sig_ff && !$past(fire_sig_ff))
        else $error("process start without fire signal edge");
    block_hold_a: assert property (block_ff && !mode_changed && !soft_rst |=> block_ff)
        else $error("short block left without mode change");
    level_follow_a: assert property ((mode_ff == MODE_LEVEL_TRIG) && !standby_ff
        && !soft_rst && !wr_mode |=> fire_bit_ff == $past(trig_s))
        else $error("fire bit not following trigger level");
    cont_fire_a: assert property (cont_mode && !standby_ff && !soft_rst && !out_short_s
        && !block_ff && !fire_bit_ff && !wr_fire |=> fire_sig_ff && !fire_bit_ff)
        else $error("continuous mode fire wrong");
    edge_toggle_a: assert property ((mode_ff == MODE_EDGE_TRIG) && trig_rise && !standby_ff
        && !soft_rst |=> fire_bit_ff != $past(fire_bit_ff))
        else $error("edge trigger did not toggle fire bit");
    done_clear_a: assert property ((mode_ff == MODE_INT_TRIG) && fire_bit_ff && sequence_done
        && !wr_fire && !soft_rst |=> !fire_bit_ff)
        else $error("fire bit not cleared at sequence end");
    oc_idle_a: assert property (!fire_sig_ff && !oc_ff && !fire_raw |=> !oc_ff)
        else $error("short detected while idle");
    oc_hold_a: assert property (oc_ff && out_short_s |=> oc_ff ##1 (oc_ff || !$past(out_short_s)))
        else $error("overcurrent flag dropped while short present");
    standby_stop_a: assert property (standby_ff |=> !fire_sig_ff ##1 !drive_out_p && !drive_out_n)
        else $error("standby did not stop playback");
    amp_clamp_a: assert property (1'b1 |=> amp_ff <= $past(overdrive_ff))
        else $error("drive amplitude above overdrive limit");
endmodule
`default_nettype wire

// ==== dv/hmp_host.sv ====
// host model that reaches the registers through the strobe port
`timescale 1ns/1ns
`default_nettype none
module hmp_host (
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // ****************************************
    // access tasks, changed on falling edges only
    // ****************************************
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        // scramble data so a stale byte is never mistaken for a write
        reg_wdata = ~d;
    endtask

    // read data is registered, so it is taken two cycles after the strobe is raised
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ==== dv/haptic_mode_process_control_bench.sv ====
// self-checking bench of the mode, fire and short handling
`timescale 1ns/1ns
`default_nettype none
module haptic_mode_process_control_bench;
    import hmp_pkg::*;
    logic clk_sys;
    logic reset_n;
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic trig;
    logic reg_short;
    logic out_short;
    logic pwm_sel;
    logic seq_done;
    logic open_loop;
    logic [7:0] amp;
    logic dout_p;
    logic p0;
    logic fire;
    logic ocf;
    logic shut;
    hmp_mode_t mode;
    logic [7:0] rd;
    logic [2:0] cmodes [3] = '{3'h3, 3'h4, 3'h5};
    int n_errors = 0;
    int total_checks = 0;

    hmp_host u_host (.clk_sys(clk_sys), .reg_rdata(rdata), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata));
    hmp_mode_ctrl #(.HALF_UNIT_CYC(4)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata), .trigger_input_pin(trig), .regulator_pin_short(reg_short),
        .output_short_sense(out_short), .pwm_not_analog_select(pwm_sel),
        .actuator_is_lra(1'b1), .open_loop_select(open_loop), .drive_half_period(5'h00),
        .dissipation_time(2'h0), .settle_blank_time(2'h0), .sequence_done(seq_done),
        .fire_signal(fire), .process_start(), .active_mode(mode), .pwm_input_active(),
        .analog_input_active(), .standby_active(), .device_shutdown(shut),
        .overcurrent_flag(ocf), .current_cut(), .drive_amplitude(amp), .peak_limit(),
        .drive_out_p(dout_p), .drive_out_n(), .output_hiz(), .adc_start());

    // ****************************************
    // clock, compare and closing tasks
    // ****************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_host.read(a, rd);
        chk8(rd, exp);
    endtask

    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // a few hundred cycles are needed; this margin is generous
    initial
    begin
        #500000;
        n_errors++;
        stop_test();
    end

    initial
    begin
        reset_n = 1'b0;
        trig = 1'b0;
        reg_short = 1'b0;
        out_short = 1'b0;
        pwm_sel = 1'b1;
        seq_done = 1'b0;
        open_loop = 1'b1;
        tick(5);
        reset_n = 1'b1;
        rchk(ADDR_MODE, 8'h40);
        rchk(ADDR_NOMINAL, NOMINAL_RST_VAL);
        rchk(ADDR_OVERDRIVE, OVERDRIVE_RST_VAL);
        rchk(8'h20, RDATA_ZERO);
        u_host.write(ADDR_MODE, 8'h00);
        u_host.write(ADDR_FIRE, 8'h01);
        tick(2);
        chk1(fire, 1'b1);
        rchk(ADDR_FIRE, 8'h01);
        seq_done = 1'b1;
        tick(1);
        seq_done = 1'b0;
        tick(2);
        rchk(ADDR_FIRE, 8'h00);
        chk1(fire, 1'b0);
        u_host.write(ADDR_FIRE, 8'h01);
        u_host.write(ADDR_FIRE, 8'h00);
        tick(2);
        chk1(fire, 1'b0);
        foreach (cmodes[i])
        begin
            u_host.write(ADDR_MODE, {5'h00, cmodes[i]});
            tick(2);
            chk1(fire, 1'b1);
            chk8({5'h00, mode}, {5'h00, cmodes[i]});
            rchk(ADDR_FIRE, 8'h00);
        end
        u_host.write(ADDR_MODE, 8'h02);
        trig = 1'b1;
        tick(8);
        rchk(ADDR_FIRE, 8'h01);
        trig = 1'b0;
        tick(8);
        chk1(fire, 1'b0);
        u_host.write(ADDR_MODE, 8'h01);
        for (int k = 0; k < 2; k++)
        begin
            trig = 1'b1;
            tick(8);
            trig = 1'b0;
            tick(8);
            rchk(ADDR_FIRE, {7'h00, k == 0});
        end
        u_host.write(ADDR_NOMINAL, 8'h50);
        u_host.write(ADDR_OVERDRIVE, 8'h60);
        tick(2);
        chk8(amp, 8'h60);
        open_loop = 1'b0;
        tick(2);
        chk8(amp, 8'h50);
        u_host.write(ADDR_OVERDRIVE, 8'h40);
        tick(2);
        chk8(amp, 8'h40);
        open_loop = 1'b1;
        u_host.write(ADDR_MODE, 8'h07);
        u_host.write(ADDR_FIRE, 8'h01);
        tick(2);
        chk1(fire, 1'b1);
        p0 = dout_p;
        tick(4);
        chk1(dout_p, !p0);
        out_short = 1'b1;
        tick(8);
        chk1(ocf, 1'b1);
        out_short = 1'b0;
        tick(8);
        chk1(ocf, 1'b0);
        u_host.write(ADDR_MODE, 8'h40);
        tick(2);
        chk1(fire, 1'b0);
        rchk(ADDR_NOMINAL, 8'h50);
        u_host.write(ADDR_MODE, 8'h80);
        tick(2);
        rchk(ADDR_MODE, 8'h40);
        rchk(ADDR_NOMINAL, NOMINAL_RST_VAL);
        u_host.write(ADDR_OVERDRIVE, 8'h11);
        reg_short = 1'b1;
        tick(8);
        chk1(shut, 1'b1);
        reg_short = 1'b0;
        tick(8);
        rchk(ADDR_OVERDRIVE, OVERDRIVE_RST_VAL);
        u_host.write(ADDR_MODE, 8'h00);
        out_short = 1'b1;
        tick(8);
        chk1(ocf, 1'b0);
        u_host.write(ADDR_FIRE, 8'h01);
        tick(2);
        chk1(fire, 1'b0);
        chk1(ocf, 1'b1);
        out_short = 1'b0;
        tick(8);
        chk1(fire, 1'b0);
        u_host.write(ADDR_MODE, 8'h01);
        tick(2);
        chk1(fire, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
